// ===== src/outcfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
module outcfg_regs (
  input  wire logic                              CLK,
  input  wire logic                              RSTN,
  input  wire logic [9:0]                        ADDRESS,
  input  wire logic                              READ,
  input  wire logic                              WRITE,
  input  wire logic [31:0]                       WRITEDATA,
  output logic [31:0]                            READDATA,
  output logic                                   WAITREQUEST,
  output logic [1:0]                             CLK_DRIVE,
  output logic                                   CLK_DRIVE_MAX,
  output logic [1:0]                             DATA_DRIVE,
  output logic                                   DATA_DRIVE_MAX,
  output logic [1:0]                             OUT_CURRENT,
  output logic                                   CLK_CURRENT_X2,
  output logic                                   DATA_CURRENT_X2,
  output logic [2:0]                             DATA_TERM,
  output logic                                   DATA_TERM_EN,
  output logic [2:0]                             CLK_TERM,
  output logic                                   CLK_TERM_EN,
  output logic                                   OFFSET_HOLD,
  input  wire logic                              SAMPLE_VALID,
  input  wire logic signed [outcfg_pkg::SAMPLE_W-1:0] SAMPLE,
  output logic                                   CORR_VALID,
  output logic signed [outcfg_pkg::SAMPLE_W-1:0] CORR_SAMPLE,
  output logic signed [outcfg_pkg::SAMPLE_W-1:0] OFFSET_EST
);

  // ****************************************************************
  // bus slave
  // ****************************************************************

  logic [7:0] clk_drive_q;
  logic [7:0] buf_cfg_q;
  logic [7:0] term_cfg_q;
  logic [7:0] hold_ctl_q;
  logic [7:0] index;
  logic       req;
  logic       done;
  logic [7:0] rd_d;

  assign index = ADDRESS[9:2];
  assign req   = READ || WRITE;
  // the access completes on the edge where waitrequest is seen low
  assign done  = req && !WAITREQUEST;

  // one wait state: answer is prepared the cycle after the request appears
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WAITREQUEST <= 1'b1;
    end else if (done) begin
      WAITREQUEST <= 1'b1;
    end else if (req) begin
      WAITREQUEST <= 1'b0;
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    unique case (index)
      outcfg_pkg::IDX_CLK_DRIVE: rd_d = clk_drive_q;
      outcfg_pkg::IDX_BUF_CFG:   rd_d = buf_cfg_q;
      outcfg_pkg::IDX_TERM_CFG:  rd_d = term_cfg_q;
      outcfg_pkg::IDX_HOLD_CTL:  rd_d = hold_ctl_q;
      default:                   rd_d = 8'h00;
    endcase
  end

  // read data held from the wait-state edge through completion
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      READDATA <= 32'h0000_0000;
    end else if (READ && WAITREQUEST) begin
      READDATA <= {24'h00_0000, rd_d};
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************

  // whole byte written at once, fixed-zero bits masked off
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      clk_drive_q <= outcfg_pkg::REG_RESET;
      buf_cfg_q   <= outcfg_pkg::REG_RESET;
      term_cfg_q  <= outcfg_pkg::REG_RESET;
      hold_ctl_q  <= outcfg_pkg::REG_RESET;
    end else if (done && WRITE) begin
      if (index == outcfg_pkg::IDX_CLK_DRIVE) begin
        clk_drive_q <= WRITEDATA[7:0] & outcfg_pkg::MASK_CLK_DRIVE;
      end
      if (index == outcfg_pkg::IDX_BUF_CFG) begin
        buf_cfg_q <= WRITEDATA[7:0] & outcfg_pkg::MASK_BUF_CFG;
      end
      if (index == outcfg_pkg::IDX_TERM_CFG) begin
        term_cfg_q <= WRITEDATA[7:0] & outcfg_pkg::MASK_TERM_CFG;
      end
      if (index == outcfg_pkg::IDX_HOLD_CTL) begin
        hold_ctl_q <= WRITEDATA[7:0] & outcfg_pkg::MASK_HOLD_CTL;
      end
    end
  end

  // ****************************************************************
  // analogue control decode
  // ****************************************************************

  logic [1:0] clk_code;
  logic [1:0] data_code;
  logic [1:0] dbl_code;
  logic [2:0] dterm;
  logic [2:0] cterm;

  assign clk_code  = clk_drive_q[outcfg_pkg::CLK_DRIVE_LSB +: 2];
  assign data_code = buf_cfg_q[outcfg_pkg::DATA_DRIVE_LSB +: 2];
  assign dbl_code  = buf_cfg_q[outcfg_pkg::DOUBLE_LSB +: 2];
  assign dterm     = term_cfg_q[outcfg_pkg::DATA_TERM_LSB +: 3];
  assign cterm     = term_cfg_q[outcfg_pkg::CLK_TERM_LSB +: 3];

  // drive levels, registered so the buffers see clean levels
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CLK_DRIVE      <= outcfg_pkg::DRIVE_DEFAULT;
      CLK_DRIVE_MAX  <= 1'b0;
      DATA_DRIVE     <= outcfg_pkg::DRIVE_DEFAULT;
      DATA_DRIVE_MAX <= 1'b0;
    end else begin
      CLK_DRIVE      <= clk_code;
      CLK_DRIVE_MAX  <= (clk_code == outcfg_pkg::DRIVE_MAXIMUM);
      DATA_DRIVE     <= data_code;
      DATA_DRIVE_MAX <= (data_code == outcfg_pkg::DRIVE_MAXIMUM);
    end
  end

  // output current and doubling; the unused code doubles nothing
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      OUT_CURRENT     <= 2'b00;
      CLK_CURRENT_X2  <= 1'b0;
      DATA_CURRENT_X2 <= 1'b0;
    end else begin
      OUT_CURRENT     <= buf_cfg_q[outcfg_pkg::CURRENT_LSB +: 2];
      CLK_CURRENT_X2  <= (dbl_code == outcfg_pkg::DOUBLE_CLK)
                      || (dbl_code == outcfg_pkg::DOUBLE_BOTH);
      DATA_CURRENT_X2 <= (dbl_code == outcfg_pkg::DOUBLE_BOTH);
    end
  end

  // termination codes plus an enable that is low for the none code
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      DATA_TERM    <= outcfg_pkg::TERM_NONE;
      DATA_TERM_EN <= 1'b0;
      CLK_TERM     <= outcfg_pkg::TERM_NONE;
      CLK_TERM_EN  <= 1'b0;
      OFFSET_HOLD  <= 1'b0;
    end else begin
      DATA_TERM    <= dterm;
      DATA_TERM_EN <= (dterm != outcfg_pkg::TERM_NONE);
      CLK_TERM     <= cterm;
      CLK_TERM_EN  <= (cterm != outcfg_pkg::TERM_NONE);
      OFFSET_HOLD  <= hold_ctl_q[outcfg_pkg::HOLD_BIT];
    end
  end

  // ****************************************************************
  // offset correction
  // ****************************************************************

  // hold taken straight from the register, a cycle ahead of OFFSET_HOLD
  offset_loop u_loop (
    .clk        (CLK),
    .rst_n      (RSTN),
    .hold       (hold_ctl_q[outcfg_pkg::HOLD_BIT]),
    .in_valid   (SAMPLE_VALID),
    .in_sample  (SAMPLE),
    .out_valid  (CORR_VALID),
    .out_sample (CORR_SAMPLE),
    .offset_est (OFFSET_EST)
  );

  // ****************************************************************
  // checks
  // ****************************************************************

  logic wr_clk_drv;
  logic wr_buf;
  logic wr_term;
  assign wr_clk_drv = done && WRITE && (index == outcfg_pkg::IDX_CLK_DRIVE);
  assign wr_buf     = done && WRITE && (index == outcfg_pkg::IDX_BUF_CFG);
  assign wr_term    = done && WRITE && (index == outcfg_pkg::IDX_TERM_CFG);

  property p_clk_max;
    @(posedge CLK) disable iff (!RSTN)
      wr_clk_drv |=> ##1 (CLK_DRIVE_MAX == ($past(WRITEDATA[7:6], 2) == 2'b10));
  endproperty
  a_clk_max: assert property (p_clk_max)
    else $error("clock maximum drive does not follow code");

  property p_data_drive;
    @(posedge CLK) disable iff (!RSTN)
      wr_buf |=> ##1 (DATA_DRIVE == $past(WRITEDATA[1:0], 2));
  endproperty
  a_data_drive: assert property (p_data_drive)
    else $error("data drive does not follow write");

  property p_current;
    @(posedge CLK) disable iff (!RSTN)
      wr_buf |=> ##1 (OUT_CURRENT == $past(WRITEDATA[3:2], 2));
  endproperty
  a_current: assert property (p_current)
    else $error("output current does not follow write");

  property p_double_clk;
    @(posedge CLK) disable iff (!RSTN)
      (wr_buf && WRITEDATA[5:4] == 2'b01) |=> ##1 (CLK_CURRENT_X2 && !DATA_CURRENT_X2);
  endproperty
  a_double_clk: assert property (p_double_clk)
    else $error("clock-only doubling wrong");

  property p_double_both;
    @(posedge CLK) disable iff (!RSTN)
      (wr_buf && WRITEDATA[5:4] == 2'b10) |=> ##1 (CLK_CURRENT_X2 && DATA_CURRENT_X2);
  endproperty
  a_double_both: assert property (p_double_both)
    else $error("both doubling wrong");

  property p_data_term;
    @(posedge CLK) disable iff (!RSTN)
      wr_term |=> ##1 (DATA_TERM == $past(WRITEDATA[5:3], 2))
               && (DATA_TERM_EN == ($past(WRITEDATA[5:3], 2) != 3'h0));
  endproperty
  a_data_term: assert property (p_data_term)
    else $error("data termination does not follow write");

  property p_clk_term;
    @(posedge CLK) disable iff (!RSTN)
      wr_term |=> ##1 (CLK_TERM == $past(WRITEDATA[2:0], 2))
               && (CLK_TERM_EN == ($past(WRITEDATA[2:0], 2) != 3'h0));
  endproperty
  a_clk_term: assert property (p_clk_term)
    else $error("clock termination does not follow write");

  property p_zero_bits;
    @(posedge CLK) disable iff (!RSTN)
      (READ && !WAITREQUEST && index == outcfg_pkg::IDX_HOLD_CTL)
        |-> (READDATA[31:5] == 27'h0 && READDATA[3:0] == 4'h0);
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("fixed-zero bits read nonzero");

  property p_one_wait;
    @(posedge CLK) disable iff (!RSTN)
      (RSTN && req && WAITREQUEST) |=> !WAITREQUEST ##1 WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("access did not finish after one wait state");

endmodule : outcfg_regs
`default_nettype wire

// ===== src/outcfg_pkg.sv
// ****************************************************************
// register map, field layout and codes
// ****************************************************************
package outcfg_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLK_DRIVE   = 8'h10;
  localparam logic [7:0] IDX_BUF_CFG     = 8'h11;
  localparam logic [7:0] IDX_TERM_CFG    = 8'h12;
  localparam logic [7:0] IDX_HOLD_CTL    = 8'h13;

  // writable bits per register; all others are fixed zero
  localparam logic [7:0] MASK_CLK_DRIVE  = 8'hc0;
  localparam logic [7:0] MASK_BUF_CFG    = 8'h3f;
  localparam logic [7:0] MASK_TERM_CFG   = 8'h3f;
  localparam logic [7:0] MASK_HOLD_CTL   = 8'h10;

  // reset value of every register
  localparam logic [7:0] REG_RESET       = 8'h00;

  // field positions (low bit)
  localparam int CLK_DRIVE_LSB  = 6;
  localparam int DATA_DRIVE_LSB = 0;
  localparam int CURRENT_LSB    = 2;
  localparam int DOUBLE_LSB     = 4;
  localparam int DATA_TERM_LSB  = 3;
  localparam int CLK_TERM_LSB   = 0;
  localparam int HOLD_BIT       = 4;

  // drive level codes
  typedef enum logic [1:0] {
    DRIVE_DEFAULT  = 2'b00,
    DRIVE_WEAKER   = 2'b01,
    DRIVE_MAXIMUM  = 2'b10,
    DRIVE_STRONGER = 2'b11
  } drive_e;

  // current doubling codes
  typedef enum logic [1:0] {
    DOUBLE_NONE    = 2'b00,
    DOUBLE_CLK     = 2'b01,
    DOUBLE_BOTH    = 2'b10,
    DOUBLE_UNUSED  = 2'b11
  } double_e;

  // termination code for no termination
  localparam logic [2:0] TERM_NONE = 3'h0;

  // offset loop: sample width and averaging shift
  localparam int SAMPLE_W  = 12;
  localparam int AVG_SHIFT = 8;
  localparam int EST_W     = SAMPLE_W + AVG_SHIFT + 1;

endpackage : outcfg_pkg

// ===== src/offset_loop.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// running offset estimate and cancellation
// ****************************************************************
module offset_loop (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              hold,
  input  wire logic                              in_valid,
  input  wire logic signed [outcfg_pkg::SAMPLE_W-1:0] in_sample,
  output logic                                   out_valid,
  output logic signed [outcfg_pkg::SAMPLE_W-1:0] out_sample,
  output logic signed [outcfg_pkg::SAMPLE_W-1:0] offset_est
);

  localparam int SW = outcfg_pkg::SAMPLE_W;
  localparam int EW = outcfg_pkg::EST_W;
  localparam int SH = outcfg_pkg::AVG_SHIFT;

  logic signed [EW-1:0] est_q;
  logic signed [EW-1:0] est_d;
  logic signed [SW:0]   diff;
  logic signed [SW-1:0] ofs;

  // first-order average: est tracks mean scaled by 2^SH
  assign ofs   = est_q[SH+SW-1:SH];
  assign est_d = est_q + EW'(in_sample) - (est_q >>> SH);
  assign diff  = (SW+1)'(in_sample) - (SW+1)'(ofs);

  // estimate frozen while hold is set; cancelling goes on either way
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      est_q <= '0;
    end else if (in_valid && !hold) begin
      est_q <= est_d;
    end
  end

  // clip the corrected sample so a large offset cannot wrap the code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid  <= 1'b0;
      out_sample <= '0;
      offset_est <= '0;
    end else begin
      out_valid  <= in_valid;
      offset_est <= ofs;
      if (diff[SW] != diff[SW-1]) begin
        out_sample <= diff[SW] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
      end else begin
        out_sample <= diff[SW-1:0];
      end
    end
  end

  // frozen estimate does not move
  property p_hold_freezes;
    @(posedge clk) disable iff (!rst_n)
      hold |=> (est_q == $past(est_q));
  endproperty
  a_hold_freezes: assert property (p_hold_freezes)
    else $error("offset estimate moved while held");

  // active loop follows its update equation
  property p_loop_updates;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && in_valid && !hold) |=> (est_q == $past(est_d));
  endproperty
  a_loop_updates: assert property (p_loop_updates)
    else $error("offset estimate not updated while active");

endmodule : offset_loop
`default_nettype wire

// ===== tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host controller on the register bus
// ****************************************************************
module host_model (
  input  wire logic        CLK,
  input  wire logic        WAITREQUEST,
  input  wire logic [31:0] READDATA,
  output logic [9:0]       ADDRESS,
  output logic             READ,
  output logic             WRITE,
  output logic [31:0]      WRITEDATA
);
  // idle bus at time zero
  initial begin
    ADDRESS   = 10'h000;
    READ      = 1'b0;
    WRITE     = 1'b0;
    WRITEDATA = 32'h0000_0000;
  end

  // one access; every field of a register travels in the same byte
  // no wait limit here: only the bench watchdog may end a stuck access
  task automatic access(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd);
    @(posedge CLK);
    ADDRESS   <= {idx, 2'b00};
    WRITE     <= we;
    READ      <= !we;
    WRITEDATA <= {24'h00_0000, wd};
    do @(posedge CLK); while (WAITREQUEST !== 1'b0);
    rd = READDATA;
    READ      <= 1'b0;
    WRITE     <= 1'b0;
    // released lines show the inverse so stale values never pass for live ones
    ADDRESS   <= ~{idx, 2'b00};
    WRITEDATA <= ~{24'h00_0000, wd};
  endtask : access
endmodule : host_model
`default_nettype wire

// ===== tb/tb_outcfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_outcfg_regs;
  logic                                   clk, rstn, read, write, waitrequest;
  logic [9:0]                             address;
  logic [31:0]                            writedata, readdata, rd;
  logic [1:0]                             clk_drive, data_drive, out_current;
  logic                                   clk_drive_max, data_drive_max, clk_x2, data_x2;
  logic [2:0]                             data_term, clk_term;
  logic                                   data_term_en, clk_term_en, offset_hold;
  logic                                   sample_valid, corr_valid;
  logic signed [outcfg_pkg::SAMPLE_W-1:0] sample, corr_sample, offset_est, est, s;
  logic [7:0]                             v;
  int                                     error_cnt, total_checks, seed;

  outcfg_regs dut_u (.CLK(clk), .RSTN(rstn), .ADDRESS(address), .READ(read), .WRITE(write),
    .WRITEDATA(writedata), .READDATA(readdata), .WAITREQUEST(waitrequest),
    .CLK_DRIVE(clk_drive), .CLK_DRIVE_MAX(clk_drive_max), .DATA_DRIVE(data_drive),
    .DATA_DRIVE_MAX(data_drive_max), .OUT_CURRENT(out_current), .CLK_CURRENT_X2(clk_x2),
    .DATA_CURRENT_X2(data_x2), .DATA_TERM(data_term), .DATA_TERM_EN(data_term_en),
    .CLK_TERM(clk_term), .CLK_TERM_EN(clk_term_en), .OFFSET_HOLD(offset_hold),
    .SAMPLE_VALID(sample_valid), .SAMPLE(sample), .CORR_VALID(corr_valid),
    .CORR_SAMPLE(corr_sample), .OFFSET_EST(offset_est));
  host_model host_u (.CLK(clk), .WAITREQUEST(waitrequest), .READDATA(readdata),
    .ADDRESS(address), .READ(read), .WRITE(write), .WRITEDATA(writedata));

  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // doubling code to {clock doubled, data doubled}; unused code doubles nothing
  function automatic logic [1:0] exp_x2(input logic [1:0] d);
    case (d)
      2'b01:   exp_x2 = 2'b10;
      2'b10:   exp_x2 = 2'b11;
      default: exp_x2 = 2'b00;
    endcase
  endfunction : exp_x2

  // sample minus held offset, clipped to the sample range
  function automatic logic [11:0] exp_corr(input logic signed [11:0] x,
                                           input logic signed [11:0] e);
    logic signed [12:0] d;
    d = 13'(x) - 13'(e);
    if (d > 13'sd2047) exp_corr = 12'h7ff;
    else if (d < -13'sd2048) exp_corr = 12'h800;
    else exp_corr = d[11:0];
  endfunction : exp_corr

  // write then read back; bits outside the mask must read zero
  task automatic cfg(input logic [7:0] idx, input logic [7:0] wd, input logic [7:0] msk);
    host_u.access(1'b1, idx, wd, rd);
    host_u.access(1'b0, idx, 8'h00, rd);
    chk(rd, {24'h00_0000, wd & msk}, "readback");
  endtask : cfg

  // samples reach the offset loop one per cycle
  task automatic feed(input logic signed [outcfg_pkg::SAMPLE_W-1:0] x);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample       <= x;
  endtask : feed

  // free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog sized well above the whole sequence
  initial begin
    #200us;
    error_cnt++;
    results();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 64719;
    rstn = 1'b0;
    sample_valid = 1'b0;
    sample = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host_u.access(1'b0, outcfg_pkg::IDX_CLK_DRIVE + 8'(i), 8'h00, rd);
      chk(rd, {24'h00_0000, outcfg_pkg::REG_RESET}, "reset value");
    end
    $display("test reset values done");
    // clock drive codes, junk in the fixed-zero bits
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], 6'($random(seed))};
      cfg(outcfg_pkg::IDX_CLK_DRIVE, v, outcfg_pkg::MASK_CLK_DRIVE);
      chk(32'(clk_drive), 32'(v[7:6]), "clock drive");
      chk(32'(clk_drive_max), 32'(v[7:6] == 2'b10), "clock drive max");
    end
    // every drive, current and doubling combination
    for (int i = 0; i < 64; i++) begin
      v = {2'($random(seed)), i[5:0]};
      cfg(outcfg_pkg::IDX_BUF_CFG, v, outcfg_pkg::MASK_BUF_CFG);
      chk(32'(data_drive), 32'(v[1:0]), "data drive");
      chk(32'(data_drive_max), 32'(v[1:0] == 2'b10), "data drive max");
      chk(32'(out_current), 32'(v[3:2]), "current");
      chk(32'({clk_x2, data_x2}), 32'(exp_x2(v[5:4])), "doubling");
    end
    // unmapped index: reads zero and must not alias the buffer register
    host_u.access(1'b1, 8'h20, 8'hff, rd);
    host_u.access(1'b0, 8'h20, 8'h00, rd);
    chk(rd, 32'h0000_0000, "unmapped read");
    host_u.access(1'b0, outcfg_pkg::IDX_BUF_CFG, 8'h00, rd);
    chk(rd, 32'(v & outcfg_pkg::MASK_BUF_CFG), "no alias");
    $display("test buffer fields done");
    for (int i = 0; i < 64; i++) begin
      v = {2'($random(seed)), i[5:0]};
      cfg(outcfg_pkg::IDX_TERM_CFG, v, outcfg_pkg::MASK_TERM_CFG);
      chk(32'({data_term_en, data_term}), 32'({v[5:3] != 3'h0, v[5:3]}), "data term");
      chk(32'({clk_term_en, clk_term}), 32'({v[2:0] != 3'h0, v[2:0]}), "clock term");
    end
    $display("test termination done");
    // loop active: a steady positive input must pull the estimate up
    cfg(outcfg_pkg::IDX_HOLD_CTL, 8'hef, outcfg_pkg::MASK_HOLD_CTL);
    chk(32'(offset_hold), 32'h0, "hold off");
    repeat (300) feed(12'sd400);
    @(negedge clk);
    chk(32'(offset_est > 0), 32'h1, "estimate moves");
    // frozen: estimate stands still and keeps cancelling
    cfg(outcfg_pkg::IDX_HOLD_CTL, 8'h10, outcfg_pkg::MASK_HOLD_CTL);
    chk(32'(offset_hold), 32'h1, "hold on");
    est = offset_est;
    for (int i = 0; i < 40; i++) begin
      // the first sample sits far below the held offset, so the clip must act
      s = (i == 0) ? 12'sh800 : 12'($signed(11'($random(seed))));
      feed(s);
      @(posedge clk);
      @(negedge clk);
      chk(32'(offset_est), 32'(est), "frozen estimate");
      chk(32'({corr_valid, corr_sample}), 32'({1'b1, exp_corr(s, est)}), "cancel");
    end
    cfg(outcfg_pkg::IDX_HOLD_CTL, 8'h00, outcfg_pkg::MASK_HOLD_CTL);
    repeat (40) feed(12'sd1500);
    @(negedge clk);
    chk(32'(offset_est != est), 32'h1, "loop resumes");
    $display("test offset hold done");
    // reset in mid-run with samples stopped clears registers and estimate
    @(posedge clk);
    rstn         <= 1'b0;
    sample_valid <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    host_u.access(1'b0, outcfg_pkg::IDX_TERM_CFG, 8'h00, rd);
    chk(rd, {24'h00_0000, outcfg_pkg::REG_RESET}, "second reset");
    chk(32'(offset_est), 32'h0, "estimate cleared");
    $display("test second reset done");
    results();
  end
endmodule : tb_outcfg_regs
`default_nettype wire
